/* src/shm_pkg.sv */
// Constants, register map and state types of the sensor health monitor.
// Assumes one primary oscillator clock and a byte-wide internal register port.
package shm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register map
  localparam logic [ADDR_W-1:0] ADDR_DEV_CTL    = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_DEV_CFG    = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_X_CFG      = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_Y_CFG      = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_DEV_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_OSC_COUNT  = 8'h15;
  localparam logic [ADDR_W-1:0] ADDR_X_STDEFL   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_Y_STDEFL   = 8'h19;

  // Field positions
  localparam int BIT_RESET_FLAG = 0;
  localparam int BIT_DEV_INIT   = 4;
  localparam int BIT_IDE        = 6;
  localparam int BIT_RES_HI     = 7;
  localparam int BIT_RES_LO     = 6;
  localparam int BIT_INIT_LOCK  = 0;
  localparam int BIT_SELFTEST   = 7;

  // Ordered reset request codes {hi, lo}
  localparam logic [1:0] RST_STEP1 = 2'h2;
  localparam logic [1:0] RST_STEP2 = 2'h1;
  localparam logic [1:0] RST_STEP3 = 2'h3;

  localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
  localparam logic [DATA_W-1:0] STDEFL_DFLT = 8'h80;

  // Oscillator monitor and clock CRC monitor
  localparam int PRESC_W = 10;
  localparam int CNT_W   = 8;
  localparam int DIV_W   = 8;
  localparam int CRC_W   = 8;
  localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
  localparam logic [CRC_W-1:0] CRC_SEED = 8'hff;
  localparam int CORES   = 2;

  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_TIME_US  = 128;
  localparam int INIT_W        = 8;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ONE  = 2'b01,
    SEQ_TWO  = 2'b10
  } shm_seq_t;

endpackage : shm_pkg

/* src/shm_mon_if.sv */
// Carrier between the health top and its two monitor modules.
// Assumes all ends share the primary oscillator clock.
`timescale 1ns/1ps
`default_nettype none
interface shm_mon_if;
  import shm_pkg::*;
  logic [CNT_W-1:0] count;
  logic             crc_mismatch;
  modport osc  (output count);
  modport crc  (output crc_mismatch);
  modport core (input count, input crc_mismatch);
endinterface : shm_mon_if
`default_nettype wire

/* src/shm_osc_mon.sv */
// Free-running oscillator-monitor counter behind a 10-bit prescaler.
// Assumes clk_in is the primary oscillator and reset is the internal reset.
`timescale 1ns/1ps
`default_nettype none
module shm_osc_mon #(
  parameter int PRESC_BITS = shm_pkg::PRESC_W
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  shm_mon_if.osc    mon
);
  import shm_pkg::*;

  localparam logic [PRESC_BITS-1:0] PRESC_MAX = {PRESC_BITS{1'b1}};

  typedef struct packed {
    logic [PRESC_BITS-1:0] presc;
    logic [CNT_W-1:0]      count;
  } shm_osc_state_t;

  shm_osc_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.presc = st_reg.presc + 1'b1;
    if (st_reg.presc == PRESC_MAX) begin
      st_next.count = st_reg.count + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read-only by construction: no write path reaches the counter
  assign mon.count = st_reg.count;

  // First edge after a reset sees the pre-reset count in $past; skip it
  a_count_step_time: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_reg.count != $past(st_reg.count) && $past(rst_n_in))
    |-> ($past(st_reg.presc) == PRESC_MAX))
    else $error("counter moved off the prescaler terminal count");

  a_count_wrap_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_reg.presc == PRESC_MAX && st_reg.count == {CNT_W{1'b1}}) |=> (st_reg.count == '0))
    else $error("counter did not wrap to zero");

endmodule : shm_osc_mon
`default_nettype wire

/* src/shm_clk_crc.sv */
// Clock CRC monitor comparing the derived clock vectors of two DSP cores.
// Assumes both divider chains run from clk_in and share the internal reset.
`timescale 1ns/1ps
`default_nettype none
module shm_clk_crc (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  shm_mon_if.crc    mon
);
  import shm_pkg::*;

  typedef struct packed {
    logic [CORES-1:0][DIV_W-1:0] div;
    logic [CORES-1:0][CRC_W-1:0] crc;
    logic                        mismatch;
  } shm_crc_state_t;

  shm_crc_state_t st_reg, st_next;
  logic [CORES-1:0][CRC_W-1:0] crc_calc;

  function automatic logic [CRC_W-1:0] crc_upd(input logic [CRC_W-1:0] c,
                                               input logic [DIV_W-1:0] d);
    logic [CRC_W-1:0] r;
    r = c;
    for (int b = DIV_W - 1; b >= 0; b--) begin
      r = (r[CRC_W-1] ^ d[b]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_upd

  // Each divider bit k is the base clock divided by 2^(k+1), down to /256
  genvar g;
  generate
    for (g = 0; g < CORES; g++) begin : g_core
      assign crc_calc[g] = crc_upd(st_reg.crc[g], st_reg.div[g]);
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < CORES; i++) begin
      st_next.div[i] = st_reg.div[i] + 1'b1;
      st_next.crc[i] = crc_calc[i];
    end
    st_next.mismatch = (st_reg.crc[0] != st_reg.crc[1]);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg     <= '0;
      st_reg.crc <= {CORES{CRC_SEED}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign mon.crc_mismatch = st_reg.mismatch;

  a_crc_every_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_reg.crc[0] != st_reg.crc[1]) |=> mon.crc_mismatch)
    else $error("core clock divergence not flagged");

endmodule : shm_clk_crc
`default_nettype wire

/* src/shm_health_top.sv */
// Safety and health monitor: reset sources, oscillator monitor, clock
// CRC monitor and self-test control of a dual-axis sensor.
// Assumes a byte-wide internal register port fed by the serial front end.
`timescale 1ns/1ps
`default_nettype none
module shm_health_top #(
  parameter int                       INIT_CYCLES = 16,
  parameter logic [shm_pkg::DATA_W-1:0] X_STDEFL  = shm_pkg::STDEFL_DFLT,
  parameter logic [shm_pkg::DATA_W-1:0] Y_STDEFL  = shm_pkg::STDEFL_DFLT
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic [shm_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  input  wire logic [shm_pkg::DATA_W-1:0]  reg_wdata_in,
  output var  logic [shm_pkg::DATA_W-1:0]  reg_rdata_out,
  input  wire logic                        ana_uv_in,
  input  wire logic                        ana_ov_in,
  input  wire logic                        dig_uv_in,
  input  wire logic                        dig_ov_in,
  input  wire logic                        int_fault_in,
  output var  logic                        dev_reset_out,
  output var  logic                        init_busy_out,
  output var  logic                        accel_fail_resp_out,
  output var  logic                        selftest_x_out,
  output var  logic                        selftest_y_out,
  output var  logic                        offs_cancel_x_out,
  output var  logic                        offs_cancel_y_out
);
  import shm_pkg::*;

  localparam logic [INIT_W-1:0] INIT_LOAD = INIT_W'(INIT_CYCLES);

  typedef struct packed {
    logic [INIT_W-1:0] init_cnt;
    logic              reset_flag;
    logic              internal_data_error_flag;
    logic              lock;
    logic              st_x;
    logic              st_y;
    logic              fail_resp;
    logic              spi_rst;
    shm_seq_t          seq;
    logic [DATA_W-1:0] rdata;
  } shm_top_state_t;

  shm_top_state_t st_reg, st_next;
  shm_mon_if      mon_bus ();

  logic              dev_rst;
  logic              ana_fail;
  logic              dig_fail;
  logic              wr_ctl;
  logic              wr_cfg;
  logic              wr_x;
  logic              wr_y;
  logic              rd_status;
  logic [1:0]        res_code;
  logic [DATA_W-1:0] status_byte;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
    return a == t;
  endfunction : hit

  // Digital regulator faults cover both ground losses
  assign dig_fail = dig_uv_in | dig_ov_in;
  assign ana_fail = ana_uv_in | ana_ov_in;
  // Internal reset: pin, digital supply fault or completed request sequence
  assign dev_rst  = !rst_n_in | dig_fail | st_reg.spi_rst;

  assign wr_ctl    = reg_wr_in & hit(reg_addr_in, ADDR_DEV_CTL);
  assign wr_cfg    = reg_wr_in & hit(reg_addr_in, ADDR_DEV_CFG);
  assign wr_x      = reg_wr_in & hit(reg_addr_in, ADDR_X_CFG);
  assign wr_y      = reg_wr_in & hit(reg_addr_in, ADDR_Y_CFG);
  assign rd_status = reg_rd_in & hit(reg_addr_in, ADDR_DEV_STATUS);
  assign res_code  = {reg_wdata_in[BIT_RES_HI], reg_wdata_in[BIT_RES_LO]};

  always_comb begin
    status_byte                 = DATA_ZERO;
    status_byte[BIT_RESET_FLAG] = st_reg.reset_flag;
    status_byte[BIT_DEV_INIT]   = (st_reg.init_cnt != '0);
    status_byte[BIT_IDE]        = st_reg.internal_data_error_flag;
  end

  shm_osc_mon u_osc (
    .clk_in   (clk_in),
    .rst_n_in (!dev_rst),
    .mon      (mon_bus.osc)
  );

  shm_clk_crc u_crc (
    .clk_in   (clk_in),
    .rst_n_in (!dev_rst),
    .mon      (mon_bus.crc)
  );

  always_comb begin
    st_next = st_reg;

    // Initialization countdown after every device reset
    if (st_reg.init_cnt != '0) begin
      st_next.init_cnt = st_reg.init_cnt - 1'b1;
    end

    // Register reads; read data held until the next read
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_DEV_CTL:    st_next.rdata = {st_reg.seq == SEQ_TWO, st_reg.seq == SEQ_ONE,
                                          {(DATA_W-2){1'b0}}};
        ADDR_DEV_CFG:    st_next.rdata = DATA_W'(st_reg.lock) << BIT_INIT_LOCK;
        ADDR_X_CFG:      st_next.rdata = DATA_W'(st_reg.st_x) << BIT_SELFTEST;
        ADDR_Y_CFG:      st_next.rdata = DATA_W'(st_reg.st_y) << BIT_SELFTEST;
        ADDR_DEV_STATUS: st_next.rdata = status_byte;
        ADDR_OSC_COUNT:  st_next.rdata = mon_bus.count;
        ADDR_X_STDEFL:   st_next.rdata = X_STDEFL;
        ADDR_Y_STDEFL:   st_next.rdata = Y_STDEFL;
        default:         st_next.rdata = DATA_ZERO;
      endcase
    end

    // Status read clears; a set in the same cycle wins below
    if (rd_status) begin
      st_next.reset_flag = 1'b0;
      st_next.internal_data_error_flag        = 1'b0;
    end
    if (st_reg.init_cnt != '0 || ana_fail) begin
      st_next.reset_flag = 1'b1;
    end
    if (int_fault_in || mon_bus.crc_mismatch) begin
      st_next.internal_data_error_flag = 1'b1;
    end

    st_next.fail_resp = ana_fail;

    // Ordered reset request; a stray control write restarts the sequence
    if (wr_ctl) begin
      case (st_reg.seq)
        SEQ_IDLE: st_next.seq = (res_code == RST_STEP1) ? SEQ_ONE : SEQ_IDLE;
        SEQ_ONE:  st_next.seq = (res_code == RST_STEP2) ? SEQ_TWO :
                                (res_code == RST_STEP1) ? SEQ_ONE : SEQ_IDLE;
        SEQ_TWO: begin
          st_next.seq     = (res_code == RST_STEP1) ? SEQ_ONE : SEQ_IDLE;
          st_next.spi_rst = (res_code == RST_STEP3);
        end
        default:  st_next.seq = SEQ_IDLE;
      endcase
    end

    // Lock is write-once until the next device reset
    if (wr_cfg && reg_wdata_in[BIT_INIT_LOCK]) begin
      st_next.lock = 1'b1;
    end
    if (wr_x && !st_reg.lock) begin
      st_next.st_x = reg_wdata_in[BIT_SELFTEST];
    end
    if (wr_y && !st_reg.lock) begin
      st_next.st_y = reg_wdata_in[BIT_SELFTEST];
    end
  end

  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      st_reg          <= '0;
      st_reg.init_cnt <= INIT_LOAD;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_out       = st_reg.rdata;
  assign dev_reset_out       = dev_rst;
  assign init_busy_out       = (st_reg.init_cnt != '0);
  assign accel_fail_resp_out = st_reg.fail_resp;
  assign selftest_x_out      = st_reg.st_x;
  assign selftest_y_out      = st_reg.st_y;
  // Offset cancellation would cancel the deflection, so it halts in self test
  assign offs_cancel_x_out   = !st_reg.st_x;
  assign offs_cancel_y_out   = !st_reg.st_y;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (dev_rst);

  // Request steps, each qualified by the progress state it must meet; the stray step by any state but SEQ_TWO
  sequence s_rst_step(logic [1:0] code);
    wr_ctl && res_code == code;
  endsequence

  sequence s_req_first;
    (st_reg.seq == SEQ_IDLE) ##0 s_rst_step(RST_STEP1);
  endsequence

  sequence s_req_second;
    (st_reg.seq == SEQ_ONE) ##0 s_rst_step(RST_STEP2);
  endsequence

  sequence s_req_armed;
    (st_reg.seq == SEQ_TWO) ##0 s_rst_step(RST_STEP3);
  endsequence

  sequence s_req_stray;
    (st_reg.seq != SEQ_TWO) ##0 s_rst_step(RST_STEP3);
  endsequence

  a_ana_fail_flag: assert property (ana_fail |=> st_reg.reset_flag && accel_fail_resp_out)
    else $error("analog fault not reported");

  a_fail_resp_clear: assert property (!ana_fail |=> !accel_fail_resp_out)
    else $error("failure response outlived analog fault");

  // Own disable: the default one would mask every digital supply fault
  a_dig_fail_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dig_fail |=> init_busy_out && !selftest_x_out && !selftest_y_out)
    else $error("digital supply fault did not reset device");

  a_seq_first_step: assert property (s_req_first |=> st_reg.seq == SEQ_ONE)
    else $error("first request step not taken");

  a_seq_second_step: assert property (s_req_second |=> st_reg.seq == SEQ_TWO)
    else $error("second request step not taken");

  a_spi_seq_reset: assert property (s_req_armed |=> dev_reset_out)
    else $error("complete request sequence did not reset");

  a_no_partial_rst: assert property (s_req_stray |=> !st_reg.spi_rst)
    else $error("reset without complete sequence");

  a_st_lock_hold: assert property (st_reg.lock && (wr_x || wr_y)
    |=> $stable(selftest_x_out) && $stable(selftest_y_out))
    else $error("self-test changed after init lock");

  a_st_offs_stop: assert property (wr_x && !st_reg.lock && reg_wdata_in[BIT_SELFTEST]
    |=> selftest_x_out && !offs_cancel_x_out)
    else $error("offset cancellation not suspended");

  a_flag_rd_clear: assert property (rd_status && !init_busy_out && !ana_fail
    |=> !st_reg.reset_flag && reg_rdata_out[BIT_RESET_FLAG] == $past(st_reg.reset_flag))
    else $error("reset flag not cleared by status read");

  a_ide_persist: assert property (int_fault_in |=> st_reg.internal_data_error_flag)
    else $error("persisting fault not re-flagged");

  a_crc_to_ide: assert property (mon_bus.crc_mismatch |=> st_reg.internal_data_error_flag)
    else $error("clock mismatch not reported");

  a_ide_rd_clear: assert property (rd_status && !int_fault_in && !mon_bus.crc_mismatch
    |=> !st_reg.internal_data_error_flag)
    else $error("internal data error not cleared by status read");

  a_init_flag_set: assert property (init_busy_out |=> st_reg.reset_flag)
    else $error("reset flag not set during initialization");

  // Reads land one cycle after the strobe, hence $past on the source
  a_status_init_bit: assert property (rd_status |=>
    reg_rdata_out[BIT_DEV_INIT] == $past(init_busy_out))
    else $error("status read shows wrong init state");

  a_y_offs_stop: assert property (wr_y && !st_reg.lock && reg_wdata_in[BIT_SELFTEST]
    |=> selftest_y_out && !offs_cancel_y_out)
    else $error("y offset cancellation not suspended");

  a_lock_sticky: assert property (st_reg.lock |=> st_reg.lock)
    else $error("init lock dropped before reset");

  a_x_cfg_read: assert property (reg_rd_in && reg_addr_in == ADDR_X_CFG
    |=> reg_rdata_out[BIT_SELFTEST] == $past(selftest_x_out))
    else $error("x self-test state misread");

  a_ctl_read: assert property (reg_rd_in && reg_addr_in == ADDR_DEV_CTL
    |=> reg_rdata_out[BIT_RES_HI] == $past(st_reg.seq == SEQ_TWO))
    else $error("request progress misread");

  // Counter is read-only: the read path returns the live count
  a_cnt_read_path: assert property (reg_rd_in && reg_addr_in == ADDR_OSC_COUNT
    |=> reg_rdata_out == $past(mon_bus.count))
    else $error("counter read returned a stale value");

  a_x_stdefl_read: assert property (reg_rd_in && reg_addr_in == ADDR_X_STDEFL
    |=> reg_rdata_out == X_STDEFL)
    else $error("x stored deflection misread");

  a_y_stdefl_read: assert property (reg_rd_in && reg_addr_in == ADDR_Y_STDEFL
    |=> reg_rdata_out == Y_STDEFL)
    else $error("y stored deflection misread");

endmodule : shm_health_top
`default_nettype wire

/* tb/shm_host_model.sv */
// Host model: the serial master of the control unit, reduced to register accesses.
// Assumes one access per strobe pulse, taken at the next rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none
module shm_host_model (
  input  wire logic                       clk_in,
  output var  logic [shm_pkg::ADDR_W-1:0] reg_addr_out,
  output var  logic                       reg_wr_out,
  output var  logic                       reg_rd_out,
  output var  logic [shm_pkg::DATA_W-1:0] reg_wdata_out
);
  import shm_pkg::*;

  initial begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_wdata_out = 8'h00;
  end

  // One strobe, held across the sampling edge; request codes sent in order by caller
  task automatic access(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic w);
    @(posedge clk_in);
    #1;
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = w;
    reg_rd_out    = !w;
    @(posedge clk_in);
    #1;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    // Released bus must not look like a stale valid value
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask : access

  // Delta self-test window from a stored code; host side only
  function automatic int st_limit(input real mn, input real mx, input int code,
                                  input real acc, input bit upper);
    real mid;
    mid = mn + (code / 255.0) * (mx - mn);
    return upper ? int'($ceil(mid * (1.0 + acc))) : int'($floor(mid * (1.0 - acc)));
  endfunction : st_limit
endmodule : shm_host_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench of the sensor health monitor top.
// Assumes shm_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import shm_pkg::*;
  logic              clk_in   = 1'b0;
  logic              rst_n_in = 1'b0;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              ana_uv = 1'b0, ana_ov = 1'b0, dig_uv = 1'b0, dig_ov = 1'b0;
  logic              int_fault = 1'b0;
  logic              dev_reset, init_busy, fail_resp, st_x, st_y, oc_x, oc_y;
  logic [DATA_W-1:0] exp_q[$];
  logic              rd_q = 1'b0;
  int                cyc = 0;
  int                miscompares = 0;
  int                cmp_count = 0;
  logic [7:0]        seq_tab [5][4] = '{'{8'h00, 8'h80, 8'h40, 8'hc0},
                                       '{8'h00, 8'h40, 8'h80, 8'hc0},
                                       '{8'h80, 8'h80, 8'h40, 8'hc0},
                                       '{8'h80, 8'h00, 8'h40, 8'hc0},
                                       '{8'h80, 8'h01, 8'h40, 8'hc0}};
  logic              seq_fires [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  always #10 clk_in = ~clk_in;

  shm_host_model host (.clk_in(clk_in), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
                       .reg_rd_out(reg_rd), .reg_wdata_out(reg_wdata));

  shm_health_top #(.INIT_CYCLES(2), .X_STDEFL(8'h00), .Y_STDEFL(8'hff)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .ana_uv_in(ana_uv), .ana_ov_in(ana_ov), .dig_uv_in(dig_uv), .dig_ov_in(dig_ov),
    .int_fault_in(int_fault), .dev_reset_out(dev_reset), .init_busy_out(init_busy),
    .accel_fail_resp_out(fail_resp), .selftest_x_out(st_x), .selftest_y_out(st_y),
    .offs_cancel_x_out(oc_x), .offs_cancel_y_out(oc_y));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Read data is looked at in the cycle after the taking edge
  always @(posedge clk_in) begin
    rd_q <= reg_rd;
    cyc  <= rst_n_in ? cyc + 1 : 0;
  end
  always @(negedge clk_in) begin
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        check("rdata_unexpected", reg_rdata, 8'hxx);
      end else begin
        check("rdata", reg_rdata, exp_q.pop_front());
      end
    end
  end

  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    host.access(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    host.access(a, 8'h00, 1'b0);
  endtask : rd
  task automatic settle();
    int n;
    n = 0;
    while ((dev_reset !== 1'b0 || init_busy !== 1'b0) && n < 50) begin
      tick();
      n++;
    end
    check("init_busy", {7'h0, init_busy}, 8'h00);
  endtask : settle
  function automatic logic [7:0] axes();
    return {4'h0, st_x, oc_x, st_y, oc_y};
  endfunction : axes

  initial begin
    void'($urandom(32'haf317531));
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    tick();
    check("init_busy", {7'h0, init_busy}, 8'h01);
    settle();
    rd(ADDR_DEV_STATUS, 8'h01);
    rd(ADDR_DEV_STATUS, 8'h00);
    rd(8'h1c, 8'h00);
    // One step per 1024 clocks: 20.48 us here, 128 us at the nominal oscillator
    for (int k = 0; k < 3; k++) begin
      while (cyc % 1024 != 512) @(posedge clk_in);
      rd(ADDR_OSC_COUNT, 8'(k));
      wr(ADDR_OSC_COUNT, 8'($urandom));
    end
    rd(ADDR_X_STDEFL, 8'h00);
    rd(ADDR_Y_STDEFL, 8'hff);
    check("st_limit_hi", 8'(host.st_limit(10.0, 20.0, 255, 0.5, 1'b1)), 8'h1e);
    check("st_limit_lo", 8'(host.st_limit(10.0, 20.0, 0, 0.5, 1'b0)), 8'h05);
    wr(ADDR_X_STDEFL, 8'($urandom) | 8'h01);
    rd(ADDR_X_STDEFL, 8'h00);
    wr(ADDR_X_CFG, 8'h80);
    wr(ADDR_Y_CFG, 8'h80);
    tick();
    check("selftest_axes", axes(), 8'h0a);
    wr(ADDR_X_CFG, 8'h00);
    wr(ADDR_DEV_CFG, 8'h01);
    wr(ADDR_X_CFG, 8'h80);
    wr(ADDR_Y_CFG, 8'h00);
    tick();
    check("locked_axes", axes(), 8'h06);
    for (int k = 0; k < 2; k++) begin
      {ana_ov, ana_uv} = 2'(k + 1);
      repeat (2) tick();
      check("fail_resp", {7'h0, fail_resp}, 8'h01);
      rd(ADDR_DEV_STATUS, 8'h01);
      {ana_ov, ana_uv} = 2'b00;
      repeat (2) tick();
      check("fail_resp", {7'h0, fail_resp}, 8'h00);
      rd(ADDR_DEV_STATUS, 8'h01);
      rd(ADDR_DEV_STATUS, 8'h00);
    end
    int_fault = 1'b1;
    repeat (2) tick();
    rd(ADDR_DEV_STATUS, 8'h40);
    rd(ADDR_DEV_STATUS, 8'h40);
    int_fault = 1'b0;
    rd(ADDR_DEV_STATUS, 8'h40);
    rd(ADDR_DEV_STATUS, 8'h00);
    for (int k = 0; k < 2; k++) begin
      {dig_ov, dig_uv} = 2'(k + 1);
      #1;
      check("dev_reset", {7'h0, dev_reset}, 8'h01);
      tick();
      check("reset_axes", axes(), 8'h05);
      {dig_ov, dig_uv} = 2'b00;
      settle();
      rd(ADDR_DEV_STATUS, 8'h01);
      rd(ADDR_DEV_STATUS, 8'h00);
    end
    // Code 8'h01 stands for an unrelated access inside the sequence
    for (int r = 0; r < 5; r++) begin
      repeat ($urandom_range(0, 3)) tick();
      for (int i = 0; i < 4; i++) begin
        if (seq_tab[r][i] == 8'h01) begin
          rd(ADDR_X_STDEFL, 8'h00);
        end else begin
          wr(ADDR_DEV_CTL, seq_tab[r][i]);
        end
      end
      check("req_reset", {7'h0, dev_reset}, {7'h0, seq_fires[r]});
      if (seq_fires[r]) begin
        tick();
        check("req_reset_len", {6'h0, dev_reset, init_busy}, 8'h01);
        settle();
        rd(ADDR_DEV_STATUS, 8'h01);
        rd(ADDR_DEV_STATUS, 8'h00);
      end
    end
    repeat (4) tick();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    check("watchdog", 8'h01, 8'h00);
    final_report();
  end
endmodule : tb
`default_nettype wire
